// ==== tpp_three_phase_pwm.sv ====
// Three-phase PWM with converter trigger, fault handling, slow timer and registers
`timescale 1ns/1ps
module tpp_three_phase_pwm
  import tpp_pkg::*;
#(
  parameter int unsigned PWM_FREQ_HZ       = DEFAULT_PWM_FREQ_HZ,
  parameter int unsigned SLOW_LOOP_RATE_HZ = DEFAULT_SLOW_LOOP_HZ
)(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [DATA_W-1:0] bus_wdata,
  input  wire logic              bus_write,
  input  wire logic              bus_read,
  output logic [DATA_W-1:0]      bus_rdata,
  input  wire logic [PHASES-1:0] fault_in,
  input  wire logic              conv_done,
  input  wire logic [CONV_W-1:0] conv_data,
  output logic [PHASES-1:0]      pwm_top,
  output logic [PHASES-1:0]      pwm_bottom,
  output logic                   conv_start,
  output logic                   conv_single_ended,
  output logic                   irq
);

  // Period count and slow match derived from clock and rates
  localparam logic [CNT_W-1:0]  PERIOD_RST = CNT_W'(CLK_HZ / PWM_FREQ_HZ);
  localparam logic [DATA_W-1:0] SLOW_RST   = DATA_W'(CLK_HZ / SLOW_LOOP_RATE_HZ);

  typedef struct packed {
    logic                          pwm_run;
    logic                          slow_en;
    logic [RATIO_W-1:0]            ratio;
    logic [CNT_W-1:0]              period;
    logic [CNT_W-1:0]              active_period;
    logic [PHASES-1:0][CNT_W-1:0]  duty;
    logic [PHASES-1:0][CNT_W-1:0]  active_duty;
    logic [CNT_W-1:0]              trig_match;
    logic [DEAD_W-1:0]             dead_ns;
    logic [DATA_W-1:0]             slow_match;
    logic [DATA_W-1:0]             slow_cnt;
    logic                          route_en;
    logic [IRQ_W-1:0]              irq_status;
    logic [IRQ_W-1:0]              irq_mask;
    logic [CONV_W-1:0]             conv_result;
    logic [RATIO_W-1:0]            opp_cnt;
    logic                          trig_armed;
    logic                          conv_start;
    logic                          single_ended;
    logic [PHASES-1:0]             fault_meta;
    logic [PHASES-1:0]             fault_sync;
    logic                          irq;
    logic [DATA_W-1:0]             rdata;
  } tpp_top_s;

  tpp_top_s s;
  tpp_top_s next_s;

  logic signed [CNT_W-1:0] init_value;
  logic signed [CNT_W-1:0] end_value;
  logic [DEAD_W-1:0]       dead_cycles;
  logic signed [CNT_W-1:0] trig_eff;
  logic                    reload;
  logic [RATIO_W:0]        opp_next;
  logic [RATIO_W:0]        ratio_ext;

  logic                    tick_out   [PHASES];
  logic signed [CNT_W-1:0] count      [PHASES];
  logic                    wrap       [PHASES];
  logic                    top_w      [PHASES];
  logic                    bot_w      [PHASES];
  logic [PHASES-1:0]       fault_act;

  // Counter runs from -period/2 up to period/2-1
  assign init_value = -$signed(CNT_W'(s.active_period >> 1));
  assign end_value  = $signed(CNT_W'(s.active_period >> 1)) - 16'sh0001;

  // Dead time held in nanoseconds, rounded up to whole clock cycles
  assign dead_cycles = DEAD_W'((32'(s.dead_ns) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Sampling point moved half a dead time past the reference
  assign trig_eff = $signed(s.trig_match) + $signed(CNT_W'(dead_cycles >> 1));

  // Every wrap of the master is an opportunity; only every nth one reloads
  assign opp_next  = {1'b0, s.opp_cnt} + 5'h01;
  assign ratio_ext = {1'b0, s.ratio};
  assign reload    = wrap[0] && (opp_next >= ratio_ext);

  generate
    for (genvar gi = 0; gi < PHASES; gi++) begin : g_phase
      logic signed [CNT_W-1:0] cmp_lo;
      logic signed [CNT_W-1:0] cmp_hi;
      logic                    tick_in;
      logic                    reinit;

      // Centre-aligned pulse of duty counts around zero
      assign cmp_lo = -$signed(CNT_W'(s.active_duty[gi] >> 1));
      assign cmp_hi = cmp_lo + $signed(s.active_duty[gi]);

      if (gi == 0) begin : g_master
        assign tick_in = s.pwm_run;
        assign reinit  = ~s.pwm_run;
      end else begin : g_slave
        assign tick_in = tick_out[0];
        assign reinit  = ~s.pwm_run | reload;
      end

      tpp_phase u_phase (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .tick_in      (tick_in),
        .reinit       (reinit),
        .reload       (reload),
        .init_value   (init_value),
        .end_value    (end_value),
        .cmp_lo       (cmp_lo),
        .cmp_hi       (cmp_hi),
        .dead_cycles  (dead_cycles),
        .fault        (s.fault_sync[gi]),
        .tick_out     (tick_out[gi]),
        .count        (count[gi]),
        .wrap         (wrap[gi]),
        .out_top      (top_w[gi]),
        .out_bottom   (bot_w[gi]),
        .fault_active (fault_act[gi])
      );

      assign pwm_top[gi]    = top_w[gi];
      assign pwm_bottom[gi] = bot_w[gi];
    end
  endgenerate

  assign bus_rdata         = s.rdata;
  assign conv_start        = s.conv_start;
  assign conv_single_ended = s.single_ended;
  assign irq               = s.irq;

  always_comb begin
    next_s = s;

    // Fault pins pass two flip-flops before use
    next_s.fault_meta = fault_in;
    next_s.fault_sync = s.fault_meta;

    // Reload opportunity counting on the master wrap
    if (!s.pwm_run) begin
      next_s.opp_cnt = '0;
    end else if (wrap[0]) begin
      next_s.opp_cnt = reload ? '0 : RATIO_W'(opp_next);
    end

    // Trigger fires once per reload, at the shifted match value
    next_s.conv_start = 1'b0;
    if (s.trig_armed && s.pwm_run && count[0] == trig_eff) begin
      next_s.trig_armed = 1'b0;
      next_s.conv_start = s.route_en;
    end

    // Shadowed duty and period become active on a reload or while stopped
    if (reload || !s.pwm_run) begin
      next_s.active_duty   = s.duty;
      next_s.active_period = s.period;
      next_s.trig_armed    = reload;
    end

    // Single-ended mode stays fixed; no software start exists
    next_s.single_ended = 1'b1;

    // Register writes
    if (bus_write) begin
      case (bus_addr)
        OFF_CTRL: begin
          next_s.pwm_run = bus_wdata[CTRL_RUN_BIT];
          next_s.slow_en = bus_wdata[CTRL_SLOW_EN_BIT];
          next_s.ratio   = bus_wdata[CTRL_RATIO_LSB +: RATIO_W];
        end
        OFF_PERIOD:     next_s.period     = bus_wdata[CNT_W-1:0];
        OFF_DUTY_A:     next_s.duty[0]    = bus_wdata[CNT_W-1:0];
        OFF_DUTY_B:     next_s.duty[1]    = bus_wdata[CNT_W-1:0];
        OFF_DUTY_C:     next_s.duty[2]    = bus_wdata[CNT_W-1:0];
        OFF_TRIG_MATCH: next_s.trig_match = bus_wdata[CNT_W-1:0];
        OFF_DEAD_NS:    next_s.dead_ns    = bus_wdata[DEAD_W-1:0];
        OFF_SLOW_MATCH: next_s.slow_match = bus_wdata;
        OFF_ROUTE:      next_s.route_en   = bus_wdata[0];
        OFF_IRQ_STATUS: next_s.irq_status = s.irq_status & ~bus_wdata[IRQ_W-1:0];
        OFF_IRQ_MASK:   next_s.irq_mask   = bus_wdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end

    // Slow-loop timer, restarting from zero at its match
    if (!s.slow_en) begin
      next_s.slow_cnt = '0;
    end else if (s.slow_cnt >= s.slow_match) begin
      next_s.slow_cnt                 = '0;
      next_s.irq_status[IRQ_SLOW_BIT] = 1'b1;
    end else begin
      next_s.slow_cnt = s.slow_cnt + 32'h0000_0001;
    end

    // Conversion result capture; events set after the clear so they win
    if (conv_done) begin
      next_s.conv_result              = conv_data;
      next_s.irq_status[IRQ_CONV_BIT] = 1'b1;
    end
    if (|s.fault_sync) begin
      next_s.irq_status[IRQ_FAULT_BIT] = 1'b1;
    end

    next_s.irq = |(next_s.irq_status & next_s.irq_mask);

    // Read data stands only in the cycle after the strobe
    next_s.rdata = '0;
    if (bus_read) begin
      case (bus_addr)
        OFF_CTRL: begin
          next_s.rdata[CTRL_RUN_BIT]              = s.pwm_run;
          next_s.rdata[CTRL_SLOW_EN_BIT]          = s.slow_en;
          next_s.rdata[CTRL_RATIO_LSB +: RATIO_W] = s.ratio;
        end
        OFF_PERIOD:     next_s.rdata[CNT_W-1:0]  = s.period;
        OFF_DUTY_A:     next_s.rdata[CNT_W-1:0]  = s.duty[0];
        OFF_DUTY_B:     next_s.rdata[CNT_W-1:0]  = s.duty[1];
        OFF_DUTY_C:     next_s.rdata[CNT_W-1:0]  = s.duty[2];
        OFF_TRIG_MATCH: next_s.rdata[CNT_W-1:0]  = s.trig_match;
        OFF_DEAD_NS:    next_s.rdata[DEAD_W-1:0] = s.dead_ns;
        OFF_SLOW_MATCH: next_s.rdata             = s.slow_match;
        OFF_ROUTE:      next_s.rdata[0]          = s.route_en;
        OFF_IRQ_STATUS: next_s.rdata[IRQ_W-1:0]  = s.irq_status;
        OFF_IRQ_MASK:   next_s.rdata[IRQ_W-1:0]  = s.irq_mask;
        OFF_CONV_DATA:  next_s.rdata[CONV_W-1:0] = s.conv_result;
        OFF_STATUS: begin
          next_s.rdata[CNT_W-1:0]                       = count[0];
          next_s.rdata[STATUS_FAULT_LSB +: PHASES]      = fault_act;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s               <= '0;
      s.ratio         <= RST_RATIO;
      s.period        <= PERIOD_RST;
      s.active_period <= PERIOD_RST;
      s.trig_match    <= RST_TRIG_MATCH;
      s.dead_ns       <= RST_DEAD_NS;
      s.slow_match    <= SLOW_RST;
      s.slow_en       <= RST_SLOW_EN;
      s.route_en      <= RST_ROUTE;
      s.irq_mask      <= RST_IRQ_MASK;
    end else begin
      s <= next_s;
    end
  end

endmodule // tpp_three_phase_pwm

// ==== tpp_pkg.sv ====
// Shared constants, register map and field layout of the three-phase PWM block
package tpp_pkg;

  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned CLK_PERIOD_NS = 5;

  localparam int unsigned PHASES  = 3;
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned CONV_W  = 12;
  localparam int unsigned RATIO_W = 4;
  localparam int unsigned DEAD_W  = 16;
  localparam int unsigned IRQ_W   = 3;

  localparam int unsigned DEFAULT_PWM_FREQ_HZ  = 10_000;
  localparam int unsigned DEFAULT_SLOW_LOOP_HZ = 1000;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PERIOD     = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DUTY_A     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DUTY_B     = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_DUTY_C     = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_TRIG_MATCH = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_DEAD_NS    = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_SLOW_MATCH = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_ROUTE      = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK   = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_CONV_DATA  = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_STATUS     = 8'h30;

  // Field positions
  localparam int unsigned CTRL_RUN_BIT      = 0;
  localparam int unsigned CTRL_SLOW_EN_BIT  = 1;
  localparam int unsigned CTRL_RATIO_LSB    = 8;
  localparam int unsigned IRQ_CONV_BIT      = 0;
  localparam int unsigned IRQ_SLOW_BIT      = 1;
  localparam int unsigned IRQ_FAULT_BIT     = 2;
  localparam int unsigned STATUS_FAULT_LSB  = 16;

  // Values after reset
  localparam logic [RATIO_W-1:0] RST_RATIO      = 4'h1;
  localparam logic [CNT_W-1:0]   RST_TRIG_MATCH = 16'h0000;
  localparam logic [DEAD_W-1:0]  RST_DEAD_NS    = 16'h01f4;
  localparam logic               RST_ROUTE      = 1'b1;
  localparam logic               RST_SLOW_EN    = 1'b1;
  localparam logic [IRQ_W-1:0]   RST_IRQ_MASK   = 3'h0;

endpackage

// ==== tpp_phase.sv ====
// One phase counter with centre-aligned compare, dead time and fault disable
`timescale 1ns/1ps
module tpp_phase
  import tpp_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    tick_in,
  input  wire logic                    reinit,
  input  wire logic                    reload,
  input  wire logic signed [CNT_W-1:0] init_value,
  input  wire logic signed [CNT_W-1:0] end_value,
  input  wire logic signed [CNT_W-1:0] cmp_lo,
  input  wire logic signed [CNT_W-1:0] cmp_hi,
  input  wire logic [DEAD_W-1:0]       dead_cycles,
  input  wire logic                    fault,
  output logic                         tick_out,
  output logic signed [CNT_W-1:0]      count,
  output logic                         wrap,
  output logic                         out_top,
  output logic                         out_bottom,
  output logic                         fault_active
);

  typedef struct packed {
    logic signed [CNT_W-1:0] count;
    logic                    ideal;
    logic [DEAD_W-1:0]       dead_cnt;
    logic                    top;
    logic                    bottom;
    logic                    fault_active;
  } tpp_phase_s;

  tpp_phase_s s;
  tpp_phase_s next_s;
  logic       ideal_now;

  // Counter tick is handed on so the following phases count on the master's tick
  assign tick_out     = tick_in;
  assign count        = s.count;
  assign out_top      = s.top;
  assign out_bottom   = s.bottom;
  assign fault_active = s.fault_active;

  always_comb begin
    next_s    = s;
    wrap      = tick_in && (s.count >= end_value);
    ideal_now = (s.count >= cmp_lo) && (s.count < cmp_hi);
    if (reinit) begin
      next_s.count = init_value;
    end else if (tick_in) begin
      next_s.count = wrap ? init_value : s.count + 16'sh0001;
    end
    next_s.ideal = ideal_now;
    if (ideal_now != s.ideal) begin
      next_s.dead_cnt = dead_cycles;
    end else if (s.dead_cnt != '0) begin
      next_s.dead_cnt = s.dead_cnt - 16'h0001;
    end
    if (fault) begin
      next_s.fault_active = 1'b1;
    end else if (reload) begin
      next_s.fault_active = 1'b0;
    end
    if (next_s.fault_active || next_s.dead_cnt != '0) begin
      next_s.top    = 1'b0;
      next_s.bottom = 1'b0;
    end else begin
      next_s.top    = ideal_now;
      next_s.bottom = ~ideal_now;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule // tpp_phase

// ==== tpp_gate_model.sv ====
// Gate driver and inverter leg model facing the six PWM outputs
`timescale 1ns/1ps
module tpp_gate_model
  import tpp_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic [PHASES-1:0] pwm_top,
  input  wire logic [PHASES-1:0] pwm_bottom,
  input  wire logic [PHASES-1:0] trip,
  output logic [PHASES-1:0]      fault_in,
  output logic [PHASES-1:0]      leg,
  output int                     shoots
);
  initial begin
    fault_in = '0;
    leg      = '0;
    shoots   = 0;
  end
  always @(posedge clk_sys) begin
    // Overcurrent comparators, one per phase leg
    fault_in <= trip;
    for (int i = 0; i < PHASES; i++) begin
      // Both switches of a leg on would short the bus
      if (pwm_top[i] && pwm_bottom[i]) begin
        shoots <= shoots + 1;
      end
      // A leg with both switches off floats: show the inverse of the last level
      leg[i] <= pwm_top[i] ? 1'b1 : (pwm_bottom[i] ? 1'b0 : ~leg[i]);
    end
  end
endmodule // tpp_gate_model

// ==== tpp_three_phase_pwm_assertions.sv ====
// Port-level checks of the three-phase PWM block
`timescale 1ns/1ps
module tpp_three_phase_pwm_assertions
  import tpp_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              bus_read,
  input wire logic [DATA_W-1:0] bus_rdata,
  input wire logic [PHASES-1:0] fault_in,
  input wire logic [PHASES-1:0] pwm_top,
  input wire logic [PHASES-1:0] pwm_bottom,
  input wire logic              conv_start,
  input wire logic              conv_single_ended,
  input wire logic              irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_no_shoot_through: assert property ((pwm_top & pwm_bottom) == 3'h0)
    else $error("top and bottom on together");
  a_top_dead_gap: assert property ($fell(pwm_top[0]) |-> !pwm_bottom[0])
    else $error("bottom on as top turns off");
  a_bottom_dead_gap: assert property ($fell(pwm_bottom[0]) |-> !pwm_top[0])
    else $error("top on as bottom turns off");
  a_rdata_idle: assert property (!$past(bus_read) |-> bus_rdata == 32'h0)
    else $error("read data outside read cycle");
  a_start_spacing: assert property (conv_start |=> !conv_start [*8])
    else $error("trigger pulses too close");
  a_single_ended: assert property (!$past(rst) |-> conv_single_ended)
    else $error("single ended flag low");
  a_fault_off: assert property (fault_in == 3'h7 [*6] |-> (pwm_top | pwm_bottom) == 3'h0)
    else $error("outputs on during fault");
  a_reset_quiet: assert property ($past(rst) |-> !conv_start && !irq)
    else $error("activity right after reset");
endmodule // tpp_three_phase_pwm_assertions

bind tpp_three_phase_pwm tpp_three_phase_pwm_assertions u_chk (
  .clk_sys(clk_sys), .rst(rst), .bus_read(bus_read), .bus_rdata(bus_rdata),
  .fault_in(fault_in), .pwm_top(pwm_top), .pwm_bottom(pwm_bottom),
  .conv_start(conv_start), .conv_single_ended(conv_single_ended), .irq(irq));

// ==== tpp_three_phase_pwm_tb.sv ====
// Register-level testbench of the three-phase PWM block
`timescale 1ns/1ps
module tpp_three_phase_pwm_tb
  import tpp_pkg::*;
;
  localparam int SLOW_HZ = 1_000_000;
  localparam int LIMIT   = 12000;
  logic              clk_sys   = 1'b0;
  logic              rst       = 1'b1;
  logic [ADDR_W-1:0] bus_addr  = '0;
  logic [DATA_W-1:0] bus_wdata = '0;
  logic              bus_write = 1'b0;
  logic              bus_read  = 1'b0;
  logic [DATA_W-1:0] bus_rdata;
  logic [PHASES-1:0] fault_in, pwm_top, pwm_bottom, leg;
  logic [PHASES-1:0] trip      = '0;
  logic              conv_done = 1'b0;
  logic [CONV_W-1:0] conv_data = 12'habc;
  logic              conv_start, conv_single_ended, irq;
  logic [DATA_W-1:0] d;
  int                shoots, n, o1, o2, o3, t1, k;
  int                n_fail = 0;
  int                n_tests = 0;
  int                cyc = 0;
  logic [ADDR_W-1:0] ra [11] = '{OFF_CTRL, OFF_PERIOD, OFF_DUTY_A, OFF_TRIG_MATCH, OFF_DEAD_NS,
    OFF_SLOW_MATCH, OFF_ROUTE, OFF_IRQ_STATUS, OFF_IRQ_MASK, OFF_STATUS, 8'h40};
  logic [DATA_W-1:0] rv [11] = '{32'h102, CLK_HZ / DEFAULT_PWM_FREQ_HZ, 0, 0, 32'h1f4,
    CLK_HZ / SLOW_HZ, 1, 0, 0, {16'h0, 16'(-(CLK_HZ / DEFAULT_PWM_FREQ_HZ / 2))}, 0};

  tpp_three_phase_pwm #(.SLOW_LOOP_RATE_HZ(SLOW_HZ)) DUT (
    .clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .fault_in(fault_in),
    .conv_done(conv_done), .conv_data(conv_data), .pwm_top(pwm_top),
    .pwm_bottom(pwm_bottom), .conv_start(conv_start),
    .conv_single_ended(conv_single_ended), .irq(irq));
  tpp_gate_model u_gate (.clk_sys(clk_sys), .pwm_top(pwm_top), .pwm_bottom(pwm_bottom),
    .trip(trip), .fault_in(fault_in), .leg(leg), .shoots(shoots));

  always #2.5 clk_sys = ~clk_sys;
  // Converter answers every trigger one cycle later
  always @(posedge clk_sys) conv_done <= conv_start;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      close_out();
    end
  end

  task close_out;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_sys);
    bus_addr  <= a;
    bus_wdata <= v;
    bus_write <= 1'b1;
    @(posedge clk_sys);
    bus_write <= 1'b0;
  endtask
  task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge clk_sys);
    bus_read <= 1'b0;
    #1 v = bus_rdata;
  endtask
  task rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    rd(a, d);
    chk(d, exp);
  endtask
  // Cycles until the next converter trigger
  task wstart(output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      #1 c++;
    end while (conv_start !== 1'b1 && c < 2000);
  endtask
  // Cycle stamp at the next edge that shows irq high
  task wirq(output int t);
    t = 0;
    do begin
      @(posedge clk_sys);
      #1 t++;
    end while (irq !== 1'b1 && t < 2000);
    t = cyc;
  endtask
  // Settle two periods, then cycles from a trigger to the next rise of phase A top
  task offs(output int c);
    wstart(c);
    wstart(c);
    c = 0;
    while (pwm_top[0] !== 1'b0 && c < 200) begin
      @(posedge clk_sys);
      #1 c++;
    end
    while (pwm_top[0] !== 1'b1 && c < 200) begin
      @(posedge clk_sys);
      #1 c++;
    end
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++) rc(ra[i], rv[i]);
    chk(DEFAULT_SLOW_LOOP_HZ, 1000);
    wr(8'h40, 32'hffffffff);
    rc(8'h40, 32'h0);
    wr(OFF_PERIOD, 32'd40);
    for (int i = 0; i < 3; i++) wr(8'(OFF_DUTY_A + 4 * i), 32'd20);
    wr(OFF_DEAD_NS, 32'd18);
    wr(OFF_CTRL, 32'h103);
    rc(OFF_STATUS, {16'h0, 16'hffed});
    wstart(n);
    wstart(n);
    chk(n, 40);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      #1 chk({pwm_top, pwm_bottom}, {{3{pwm_top[0]}}, {3{pwm_bottom[0]}}});
    end
    wr(OFF_CTRL, 32'h303);
    wstart(n);
    wstart(n);
    chk(n, 120);
    wr(OFF_CTRL, 32'h103);
    offs(o1);
    wr(OFF_DEAD_NS, 32'd38);
    offs(o2);
    chk(32'(o2 - o1), 2);
    wr(OFF_DEAD_NS, 32'd18);
    wr(OFF_TRIG_MATCH, 32'd5);
    offs(o3);
    chk(32'(o1 - o3), 5);
    wr(OFF_ROUTE, 32'hfffffffe);
    rc(OFF_ROUTE, 32'h0);
    k = 0;
    repeat (100) begin
      @(posedge clk_sys);
      #1 k += int'(conv_start);
    end
    chk(k, 0);
    wr(OFF_ROUTE, 32'h1);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_IRQ_STATUS, 32'h7);
    wstart(n);
    repeat (3) @(posedge clk_sys);
    rc(OFF_CONV_DATA, 32'habc);
    chk(irq, 1'b1);
    wr(OFF_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clk_sys);
    #1 chk(irq, 1'b0);
    wstart(n);
    repeat (4) @(posedge clk_sys);
    wr(OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_sys);
    #1 chk(irq, 1'b0);
    wr(OFF_CTRL, 32'h101);
    wr(OFF_SLOW_MATCH, 32'd49);
    wr(OFF_IRQ_MASK, 32'h2);
    wr(OFF_IRQ_STATUS, 32'h7);
    wr(OFF_CTRL, 32'h103);
    #1 t1 = cyc;
    wirq(k);
    chk(k - t1, 50);
    t1 = k;
    wr(OFF_IRQ_STATUS, 32'h2);
    wirq(k);
    chk(k - t1, 50);
    wstart(n);
    trip <= 3'h7;
    repeat (8) @(posedge clk_sys);
    #1 chk({pwm_top, pwm_bottom}, 0);
    rd(OFF_STATUS, d);
    chk(d[18:16], 3'h7);
    rc(OFF_IRQ_STATUS, 32'h7);
    trip <= 3'h0;
    repeat (6) @(posedge clk_sys);
    #1 chk({pwm_top, pwm_bottom}, 0);
    wstart(n);
    wstart(n);
    rd(OFF_STATUS, d);
    chk(d[18:16], 3'h0);
    chk(pwm_top | pwm_bottom, 3'h7);
    chk(shoots, 0);
    close_out();
  end
endmodule // tpp_three_phase_pwm_tb
